// ===== src/mhc_top.sv
`timescale 1ns/1ps
`default_nettype none

module mhc_top
  import mhc_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output logic [7:0]       RDATA,
  output logic             IRQ,
  output logic             REQUEST_TO_SEND_N_PORT1,
  output logic             REQUEST_TO_SEND_N_PORT2_OUT,
  input  wire logic        REQUEST_TO_SEND_N_PORT2_IN,
  output logic             REQUEST_TO_SEND_N_PORT2_OE_N,
  output logic             TERMINAL_READY_N_PORT1,
  output logic             TERMINAL_READY_N_PORT2,
  input  wire logic        CLEAR_TO_SEND_N_PORT1,
  input  wire logic        CLEAR_TO_SEND_N_PORT2,
  input  wire logic        DATA_SET_READY_N_PORT1,
  input  wire logic        DATA_SET_READY_N_PORT2,
  input  wire logic        CARRIER_DETECT_N_PORT1,
  input  wire logic        CARRIER_DETECT_N_PORT2,
  input  wire logic        RING_INDICATOR_N_PORT1,
  input  wire logic        RING_INDICATOR_N_PORT2,
  output logic             CONFIG_BASE_STRAP,
  output logic [15:0]      CONFIG_INDEX_BASE
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [1:0][3:0] pins_raw;
  logic [1:0][3:0] pins_sync;
  logic [7:0]      mcr_q [NUM_PORTS];
  logic            ier_q [NUM_PORTS];
  logic [1:0][7:0] modem_status_reg;
  logic [1:0]      msr_rd;
  logic [1:0]      port_change;
  logic [1:0]      irq_event;
  logic [1:0]      irq_stat_q;
  logic [1:0]      irq_mask_q;
  logic            irq_q;
  logic            rts_n_q [NUM_PORTS];
  logic            dtr_n_q [NUM_PORTS];
  logic            rts2_oe_n_q;
  logic            strap_sync;
  logic            strap_q;
  logic [15:0]     index_base_q;
  logic [2:0]      settle_q;
  mhc_strap_e      strap_st_q;
  logic [7:0]      rdata_q;
  logic [7:0]      rd_mux;
  logic            irq_stat_rd;

  assign pins_raw[0] = {CARRIER_DETECT_N_PORT1, RING_INDICATOR_N_PORT1,
                        DATA_SET_READY_N_PORT1, CLEAR_TO_SEND_N_PORT1};
  assign pins_raw[1] = {CARRIER_DETECT_N_PORT2, RING_INDICATOR_N_PORT2,
                        DATA_SET_READY_N_PORT2, CLEAR_TO_SEND_N_PORT2};

  // ****************************************************************
  // per-port handshake logic
  // ****************************************************************
  // clear-to-send goes only to status and interrupt; nothing here gates a transmitter
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    for (genvar b = 0; b < 4; b++) begin : g_pin
      mhc_sync u_sync (
        .clk      (SYS_CLK),
        .rst_n    (RESET_N),
        .async_in (pins_raw[p][b]),
        .sync_out (pins_sync[p][b])
      );
    end

    assign msr_rd[p] = RD_STB && ADDR == 4'(p * PORT_STRIDE + OFF_MODEM_STAT);

    mhc_port u_port (
      .clk       (SYS_CLK),
      .rst_n     (RESET_N),
      .pins_n    (pins_sync[p]),
      .status_rd (msr_rd[p]),
      .status    (modem_status_reg[p]),
      .change    (port_change[p])
    );

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        mcr_q[p] <= MCR_RESET;
        ier_q[p] <= IER_RESET;
      end else if (WR_STB) begin
        if (ADDR == 4'(p * PORT_STRIDE + OFF_MODEM_CTRL)) begin
          mcr_q[p] <= WDATA & 8'h13;
        end
        if (ADDR == 4'(p * PORT_STRIDE + OFF_INT_ENABLE)) begin
          ier_q[p] <= WDATA[IER_MODEM_BIT];
        end
      end
    end

    // loopback wins over the control bits
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        rts_n_q[p] <= 1'b1;
        dtr_n_q[p] <= 1'b1;
      end else begin
        rts_n_q[p] <= ~mcr_q[p][MCR_RTS_BIT] | mcr_q[p][MCR_LOOP_BIT];
        dtr_n_q[p] <= ~mcr_q[p][MCR_DTR_BIT] | mcr_q[p][MCR_LOOP_BIT];
      end
    end

    assign irq_event[p] = port_change[p] & ier_q[p];
  end

  // ****************************************************************
  // strap capture
  // ****************************************************************
  mhc_sync u_strap_sync (
    .clk      (SYS_CLK),
    .rst_n    (RESET_N),
    .async_in (REQUEST_TO_SEND_N_PORT2_IN),
    .sync_out (strap_sync)
  );

  // pin stays released until the synchroniser has seen the strap level
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_st_q <= MHC_ST_SETTLE;
      settle_q   <= 3'h0;
    end else begin
      unique case (strap_st_q)
        MHC_ST_SETTLE: begin
          settle_q <= settle_q + 3'h1;
          if (settle_q == STRAP_SETTLE) begin
            strap_st_q <= MHC_ST_RUN;
          end
        end
        MHC_ST_RUN: begin
          settle_q <= settle_q;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_q      <= PIN_IDLE;
      index_base_q <= INDEX_BASE_HIGH;
      rts2_oe_n_q  <= 1'b1;
    end else if (strap_st_q == MHC_ST_SETTLE && settle_q == STRAP_SETTLE) begin
      strap_q      <= strap_sync;
      index_base_q <= strap_sync ? INDEX_BASE_HIGH : INDEX_BASE_LOW;
      rts2_oe_n_q  <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  assign irq_stat_rd = RD_STB && ADDR == OFF_IRQ_STAT;

  // an event in the read cycle wins over the clear
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~{2{irq_stat_rd}}) | irq_event;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (WR_STB && ADDR == OFF_IRQ_MASK) begin
      irq_mask_q <= WDATA[1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    rd_mux = 8'h00;
    unique case (ADDR)
      OFF_MODEM_CTRL:               rd_mux = mcr_q[0];
      OFF_MODEM_STAT:               rd_mux = modem_status_reg[0];
      OFF_INT_ENABLE:               rd_mux = 8'(ier_q[0]) << IER_MODEM_BIT;
      PORT_STRIDE + OFF_MODEM_CTRL: rd_mux = mcr_q[1];
      PORT_STRIDE + OFF_MODEM_STAT: rd_mux = modem_status_reg[1];
      PORT_STRIDE + OFF_INT_ENABLE: rd_mux = 8'(ier_q[1]) << IER_MODEM_BIT;
      OFF_IRQ_STAT:                 rd_mux = {6'h00, irq_stat_q};
      OFF_IRQ_MASK:                 rd_mux = {6'h00, irq_mask_q};
      OFF_CONFIG:                   rd_mux = {7'h00, strap_q};
      default:                      rd_mux = 8'h00;
    endcase
  end

  // data stand in the cycle after the strobe and read zero otherwise
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= RD_STB ? rd_mux : 8'h00;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign RDATA                        = rdata_q;
  assign IRQ                          = irq_q;
  assign REQUEST_TO_SEND_N_PORT1      = rts_n_q[0];
  assign REQUEST_TO_SEND_N_PORT2_OUT  = rts_n_q[1];
  assign REQUEST_TO_SEND_N_PORT2_OE_N = rts2_oe_n_q;
  assign TERMINAL_READY_N_PORT1       = dtr_n_q[0];
  assign TERMINAL_READY_N_PORT2       = dtr_n_q[1];
  assign CONFIG_BASE_STRAP            = strap_q;
  assign CONFIG_INDEX_BASE            = index_base_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_rts_follows_ctrl: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    mcr_q[0][MCR_RTS_BIT] && !mcr_q[0][MCR_LOOP_BIT] |=> !REQUEST_TO_SEND_N_PORT1)
    else $error("rts not asserted after control bit set");

  a_rts_idle_ctrl: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !mcr_q[1][MCR_RTS_BIT] |=> REQUEST_TO_SEND_N_PORT2_OUT)
    else $error("rts asserted with control bit clear");

  a_rts_reset_high: assert property (@(posedge SYS_CLK)
    $rose(RESET_N) |-> REQUEST_TO_SEND_N_PORT1 && REQUEST_TO_SEND_N_PORT2_OUT)
    else $error("rts not inactive out of reset");

  a_rts_loop_held: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    mcr_q[0][MCR_LOOP_BIT] [*2] |-> REQUEST_TO_SEND_N_PORT1)
    else $error("rts active during loopback");

  a_strap_base_pick: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $fell(REQUEST_TO_SEND_N_PORT2_OE_N) |->
      CONFIG_INDEX_BASE == (strap_q ? INDEX_BASE_HIGH : INDEX_BASE_LOW)
      && strap_q == $past(strap_sync))
    else $error("index base does not match strap");

  a_strap_held: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !REQUEST_TO_SEND_N_PORT2_OE_N |=> $stable(CONFIG_INDEX_BASE))
    else $error("index base moved after strap capture");

  a_dtr_follows_ctrl: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    mcr_q[1][MCR_DTR_BIT] && !mcr_q[1][MCR_LOOP_BIT] |=> !TERMINAL_READY_N_PORT2)
    else $error("dtr not asserted after control bit set");

  a_dtr_reset_high: assert property (@(posedge SYS_CLK)
    $rose(RESET_N) |-> TERMINAL_READY_N_PORT1 && TERMINAL_READY_N_PORT2)
    else $error("dtr not inactive out of reset");

  a_dtr_loop_held: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    mcr_q[1][MCR_LOOP_BIT] |=> TERMINAL_READY_N_PORT2)
    else $error("dtr active during loopback");

  a_cts_level_read: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    RD_STB && ADDR == OFF_MODEM_STAT |=>
      RDATA[MSR_LEVEL_LSB + PIN_CTS] == ~$past(pins_sync[0][PIN_CTS]))
    else $error("cts level bit not complement of input");

  a_irq_on_change: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    port_change[1] && ier_q[1] && irq_mask_q[1] |=> irq_stat_q[1] ##1 IRQ)
    else $error("modem change did not raise interrupt");

  a_no_irq_disabled: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    irq_stat_q == 2'h0 |=> !IRQ)
    else $error("interrupt with no pending status");

endmodule : mhc_top
`default_nettype wire

// ===== src/mhc_pkg.sv
// ****************************************************************
// modem handshake control constants
// ****************************************************************
package mhc_pkg;

  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 8;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] PORT_STRIDE    = 4'h4;
  localparam logic [3:0] OFF_MODEM_CTRL = 4'h0;
  localparam logic [3:0] OFF_MODEM_STAT = 4'h1;
  localparam logic [3:0] OFF_INT_ENABLE = 4'h2;
  localparam logic [3:0] OFF_IRQ_STAT   = 4'h8;
  localparam logic [3:0] OFF_IRQ_MASK   = 4'h9;
  localparam logic [3:0] OFF_CONFIG     = 4'hA;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned MCR_DTR_BIT   = 0;
  localparam int unsigned MCR_RTS_BIT   = 1;
  localparam int unsigned MCR_LOOP_BIT  = 4;
  localparam int unsigned IER_MODEM_BIT = 3;
  localparam int unsigned MSR_LEVEL_LSB = 4;
  // handshake input index: change flag bit i, level bit 4+i
  localparam int unsigned PIN_CTS = 0;
  localparam int unsigned PIN_DSR = 1;
  localparam int unsigned PIN_RI  = 2;
  localparam int unsigned PIN_DCD = 3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] MCR_RESET      = 8'h00;
  localparam logic       IER_RESET      = 1'b0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic       PIN_IDLE       = 1'b1;
  localparam logic [3:0] PINS_IDLE      = 4'hF;

  // ****************************************************************
  // strap and index base
  // ****************************************************************
  localparam logic [15:0] INDEX_BASE_LOW  = 16'h03F0;
  localparam logic [15:0] INDEX_BASE_HIGH = 16'h0370;
  localparam logic [2:0]  STRAP_SETTLE    = 3'h4;

  typedef enum logic {
    MHC_ST_SETTLE = 1'b0,
    MHC_ST_RUN    = 1'b1
  } mhc_strap_e;

endpackage : mhc_pkg

// ===== src/mhc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mhc_sync
  import mhc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  // only s2 reads s1; a change counts once s2 and s3 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= PIN_IDLE;
      s2_q  <= PIN_IDLE;
      s3_q  <= PIN_IDLE;
      out_q <= PIN_IDLE;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end

  assign sync_out = out_q;

  a_sync_agree_only: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(out_q) |-> $past(s2_q) == $past(s3_q))
    else $error("sync output moved without agreement");

endmodule : mhc_sync
`default_nettype wire

// ===== src/mhc_port.sv
`timescale 1ns/1ps
`default_nettype none
module mhc_port
  import mhc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] pins_n,
  input  wire logic       status_rd,
  output logic [7:0]      status,
  output logic            change
);

  logic [3:0] prev_q;
  logic [3:0] delta_q;
  logic [3:0] rise;

  assign rise   = pins_n & ~prev_q;
  assign change = |(pins_n ^ prev_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= PINS_IDLE;
    end else begin
      prev_q <= pins_n;
    end
  end

  // a rise in the read cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delta_q <= 4'h0;
    end else begin
      delta_q <= (delta_q & ~{4{status_rd}}) | rise;
    end
  end

  assign status = {~pins_n, delta_q};

  a_delta_on_rise: assert property (@(posedge clk) disable iff (!rst_n)
    rise != 4'h0 |=> (delta_q & $past(rise)) == $past(rise))
    else $error("rising handshake input did not set its change flag");

  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
    status_rd && rise == 4'h0 |=> delta_q == 4'h0)
    else $error("status read did not clear change flags");

endmodule : mhc_port
`default_nettype wire

// ===== verif/mhc_modem.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// modem side of both ports, plus the strap resistor on rts2
// ****************************************************************
module mhc_modem (
  input  wire logic       clk,
  input  wire logic       rts2_out,
  input  wire logic       rts2_oe_n,
  output logic            rts2_pin,
  output logic [3:0]      pins1_n,
  output logic [3:0]      pins2_n
);
  logic strap_lvl;

  initial begin
    strap_lvl = 1'b0;
    pins1_n   = 4'hF;
    pins2_n   = 4'hF;
  end

  // strap resistor wins only while the pin is released
  assign rts2_pin = rts2_oe_n ? strap_lvl : rts2_out;

  // lines move just after an edge and then hold
  task automatic set_pin(input int port, input int idx, input logic val);
    @(posedge clk);
    if (port == 0) begin
      pins1_n[idx] <= val;
    end else begin
      pins2_n[idx] <= val;
    end
  endtask : set_pin

  task automatic set_strap(input logic val);
    @(posedge clk);
    strap_lvl <= val;
  endtask : set_strap
endmodule : mhc_modem
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import mhc_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rdata;
  logic        irq;
  logic        rts1_n;
  logic        rts2_out;
  logic        rts2_oe_n;
  logic        rts2_pin;
  logic        dtr1_n;
  logic        dtr2_n;
  logic [3:0]  pins1_n;
  logic [3:0]  pins2_n;
  logic        strap;
  logic [15:0] base;
  int          errors;
  int          compares;
  int          cycles;
  logic [7:0]  d;
  logic [7:0]  mcr_tab [5];

  mhc_top u_dut (
    .SYS_CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .IRQ(irq), .REQUEST_TO_SEND_N_PORT1(rts1_n),
    .REQUEST_TO_SEND_N_PORT2_OUT(rts2_out), .REQUEST_TO_SEND_N_PORT2_IN(rts2_pin),
    .REQUEST_TO_SEND_N_PORT2_OE_N(rts2_oe_n), .TERMINAL_READY_N_PORT1(dtr1_n),
    .TERMINAL_READY_N_PORT2(dtr2_n), .CLEAR_TO_SEND_N_PORT1(pins1_n[0]),
    .CLEAR_TO_SEND_N_PORT2(pins2_n[0]), .DATA_SET_READY_N_PORT1(pins1_n[1]),
    .DATA_SET_READY_N_PORT2(pins2_n[1]), .RING_INDICATOR_N_PORT1(pins1_n[2]),
    .RING_INDICATOR_N_PORT2(pins2_n[2]), .CARRIER_DETECT_N_PORT1(pins1_n[3]),
    .CARRIER_DETECT_N_PORT2(pins2_n[3]), .CONFIG_BASE_STRAP(strap),
    .CONFIG_INDEX_BASE(base)
  );

  mhc_modem u_modem (
    .clk(clk), .rts2_out(rts2_out), .rts2_oe_n(rts2_oe_n), .rts2_pin(rts2_pin),
    .pins1_n(pins1_n), .pins2_n(pins2_n)
  );

  // ****************************************************************
  // bus tasks and checking
  // ****************************************************************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitc

  task automatic close_out();
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // ****************************************************************
  // clock, reset and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic do_reset(input logic lvl);
    u_modem.set_strap(lvl);
    rst_n <= 1'b0;
    waitc(2);
    chk("rts1_rst", 16'(rts1_n), 16'h0001);
    chk("rts2_rst", 16'(rts2_pin), 16'(lvl));
    chk("dtr_rst", 16'({dtr1_n, dtr2_n}), 16'h0003);
    chk("strap_rst", 16'({strap, base}), 17'h1_0370);
    rst_n <= 1'b1;
    waitc(10);
    chk("strap", 16'(strap), 16'(lvl));
    chk("index_base", base, lvl ? 16'h0370 : 16'h03F0);
    rd(OFF_CONFIG, d);
    chk("config_reg", 16'(d), 16'(lvl));
  endtask : do_reset

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [3:0] pb;
    logic       exp_rts;
    logic       exp_dtr;
    errors   = 0;
    compares = 0;
    cycles   = 0;
    rst_n    = 1'b0;
    addr     = 4'h0;
    wdata    = 8'h00;
    wr_stb   = 1'b0;
    rd_stb   = 1'b0;
    mcr_tab  = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h13};
    do_reset(1'b0);
    for (int p = 0; p < 2; p++) begin
      pb = p[0] ? PORT_STRIDE : 4'h0;
      // control bits to pins, loop bit forcing both inactive
      foreach (mcr_tab[k]) begin
        wr(pb + OFF_MODEM_CTRL, mcr_tab[k]);
        waitc(2);
        exp_rts = !(mcr_tab[k][1] && !mcr_tab[k][4]);
        exp_dtr = !(mcr_tab[k][0] && !mcr_tab[k][4]);
        chk("rts", 16'(p[0] ? rts2_pin : rts1_n), 16'(exp_rts));
        chk("dtr", 16'(p[0] ? dtr2_n : dtr1_n), 16'(exp_dtr));
        rd(pb + OFF_MODEM_CTRL, d);
        chk("mcr_read", 16'(d), 16'(mcr_tab[k]));
      end
      wr(pb + OFF_MODEM_CTRL, 8'h00);
      // level bits and change flags, one line at a time
      for (int i = 0; i < 4; i++) begin
        u_modem.set_pin(p, i, 1'b0);
        waitc(8);
        rd(pb + OFF_MODEM_STAT, d);
        chk("msr_level", 16'(d), 16'(8'h01 << (4 + i)));
        u_modem.set_pin(p, i, 1'b1);
        waitc(8);
        rd(pb + OFF_MODEM_STAT, d);
        chk("msr_change", 16'(d), 16'(8'h01 << i));
        rd(pb + OFF_MODEM_STAT, d);
        chk("msr_cleared", 16'(d), 16'h0000);
      end
      // the other port saw none of this
      rd((p[0] ? 4'h0 : PORT_STRIDE) + OFF_MODEM_STAT, d);
      chk("other_msr", 16'(d), 16'h0000);
      // interrupt on either edge, masked, and disabled
      wr(pb + OFF_INT_ENABLE, 8'h08);
      rd(pb + OFF_INT_ENABLE, d);
      chk("ier_read", 16'(d), 16'h0008);
      wr(OFF_IRQ_MASK, 8'h03);
      u_modem.set_pin(p, PIN_DSR, 1'b0);
      waitc(8);
      chk("irq_on", 16'(irq), 16'h0001);
      rd(OFF_IRQ_STAT, d);
      chk("irq_stat", 16'(d), 16'(8'h01 << p));
      waitc(2);
      chk("irq_off", 16'(irq), 16'h0000);
      wr(OFF_IRQ_MASK, 8'h00);
      u_modem.set_pin(p, PIN_DSR, 1'b1);
      waitc(8);
      chk("irq_masked", 16'(irq), 16'h0000);
      rd(OFF_IRQ_STAT, d);
      chk("irq_sticky", 16'(d), 16'(8'h01 << p));
      wr(pb + OFF_INT_ENABLE, 8'h00);
      wr(OFF_IRQ_MASK, 8'h03);
      u_modem.set_pin(p, PIN_CTS, 1'b0);
      waitc(8);
      rd(OFF_IRQ_STAT, d);
      chk("irq_disabled", 16'({irq, d}), 16'h0000);
      u_modem.set_pin(p, PIN_CTS, 1'b1);
      waitc(8);
      rd(pb + OFF_MODEM_STAT, d);
      chk("msr_both", 16'(d), 16'h0003);
    end
    // holes in the map read zero and ignore writes
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    chk("unmapped_f", 16'(d), 16'h0000);
    rd(4'h3, d);
    chk("unmapped_3", 16'(d), 16'h0000);
    do_reset(1'b1);
    close_out();
  end
endmodule : tb
`default_nettype wire
